// File: rtl/lcdtc_core.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module lcdtc_core #(
   parameter int unsigned ADDR_W = 7
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_b_i,
   input  wire logic                      ce_i,
   // Documented panel reset pin, active low, asynchronous to clk_sys_i
   input  wire logic                      lcd_reset_b_i,
   input  wire logic [4:0]                mode_pins_i,
   input  wire logic [7:0]                mem_data_i,
   output lcdtc_pkg::lcdtc_disp_s         disp_o,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [ADDR_W-1:0]         s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);

   localparam int unsigned PIN_W = 1 + lcdtc_pkg::MODE_W + lcdtc_pkg::MD_W;

   if (ADDR_W < lcdtc_pkg::ADDR_W_MIN) begin : g_chk
      $error("lcdtc_core needs ADDR_W of at least 7");
   end

   // Pin synchronisers
   logic [PIN_W-1:0] pins_sync;
   logic             pin_rst;
   logic [4:0]       mode_pins;
   logic [7:0]       md;

   lcdtc_sync #(
      .WIDTH   (PIN_W),
      .STAGES  (lcdtc_pkg::SYNC_STAGES),
      .RST_VAL ({1'b1, {(PIN_W-1){1'b0}}})
   ) u_pin_sync (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .async_i   ({lcd_reset_b_i, mode_pins_i, mem_data_i}),
      .sync_o    (pins_sync)
   );

   // Reset level alone decides, no other pin gates it
   assign pin_rst   = ~pins_sync[PIN_W-1];
   assign mode_pins = pins_sync[PIN_W-2 -: lcdtc_pkg::MODE_W];
   assign md        = pins_sync[lcdtc_pkg::MD_W-1:0];

   // Register file, cleared only by the system reset
   logic [7:0] regs [lcdtc_pkg::REG_COUNT];

   // Write channel
   logic              aw_full;
   logic [4:0]        aw_idx;
   logic              w_full;
   logic [7:0]        w_byte;
   logic              w_lane0;
   logic              do_write;
   logic              wr_hit;
   logic              bvalid_q;
   logic [1:0]        bresp_q;

   assign s_axi_awready = ce_i & ~aw_full & ~bvalid_q;
   assign s_axi_wready  = ce_i & ~w_full & ~bvalid_q;
   assign do_write      = ce_i & aw_full & w_full & ~bvalid_q;
   assign wr_hit        = lcdtc_pkg::IMPL_MASK[aw_idx];
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   // Write channel never looks at the panel reset pin; only the read status word does
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_full  <= 1'b0;
         aw_idx   <= 5'h00;
         w_full   <= 1'b0;
         w_byte   <= 8'h00;
         w_lane0  <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= lcdtc_pkg::RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_idx  <= s_axi_awaddr[6:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full  <= 1'b1;
            w_byte  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_full  <= 1'b0;
            w_full   <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? lcdtc_pkg::RESP_OKAY : lcdtc_pkg::RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Panel reset never reaches the registers
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < lcdtc_pkg::REG_COUNT; i++) regs[i] <= lcdtc_pkg::REG_RST_VAL;
      end else if (do_write && wr_hit && w_lane0) begin
         regs[aw_idx] <= w_byte;
      end
   end

   // Programmed settings
   logic [7:0]  nht;
   logic [7:0]  nhd;
   logic [4:0]  nr;
   logic [4:0]  ncs;
   logic [4:0]  nce;
   logic        cur_p;
   logic        cur_b;
   logic [15:0] start_addr;
   logic [15:0] cur_addr;
   logic [7:0]  nir;
   logic [8:0]  nd;
   logic [4:0]  nsr;
   logic [4:0]  mode;

   assign nht        = regs[lcdtc_pkg::IDX_HTOTAL];
   assign nhd        = regs[lcdtc_pkg::IDX_HDISP];
   assign nr         = regs[lcdtc_pkg::IDX_MAXRAS][4:0];
   assign ncs        = regs[lcdtc_pkg::IDX_CUR_START][4:0];
   assign cur_p      = regs[lcdtc_pkg::IDX_CUR_START][lcdtc_pkg::CUR_P_BIT];
   assign cur_b      = regs[lcdtc_pkg::IDX_CUR_START][lcdtc_pkg::CUR_B_BIT];
   assign nce        = regs[lcdtc_pkg::IDX_CUR_END][4:0];
   assign start_addr = {regs[lcdtc_pkg::IDX_START_H], regs[lcdtc_pkg::IDX_START_L]};
   assign cur_addr   = {regs[lcdtc_pkg::IDX_CUR_H], regs[lcdtc_pkg::IDX_CUR_L]};
   assign nir        = regs[lcdtc_pkg::IDX_VWIDTH];
   assign nd         = {regs[lcdtc_pkg::IDX_DUTY_H][0], regs[lcdtc_pkg::IDX_DUTY_L]};
   assign nsr        = regs[lcdtc_pkg::IDX_SCROLL][4:0];
   // Register bits and mode pins are ORed
   assign mode       = regs[lcdtc_pkg::IDX_MODE][4:0] | mode_pins;

   // Timing state
   lcdtc_pkg::lcdtc_state_e state;
   lcdtc_pkg::lcdtc_state_e next_state;
   logic [7:0]              hcnt;
   logic [4:0]              ras;
   logic [8:0]              lcnt;
   logic [15:0]             row_addr;
   logic [5:0]              fcnt;
   lcdtc_pkg::lcdtc_disp_s  disp_q;
   lcdtc_pkg::lcdtc_disp_s  run_val;
   lcdtc_pkg::lcdtc_disp_s  hold_val;
   lcdtc_pkg::lcdtc_disp_s  next_disp;
   logic [7:0]              next_hcnt;
   logic [4:0]              next_ras;
   logic [8:0]              next_lcnt;
   logic [15:0]             next_row_addr;
   logic [5:0]              next_fcnt;

   logic        line_end;
   logic        row_end;
   logic        frame_end;
   logic        window;
   logic [15:0] ma_now;
   logic        cur_visible;
   logic        cursor_now;
   logic        graphic;
   logic        entering;
   logic        drop_low;

   assign line_end  = hcnt == nht;
   assign row_end   = ras == nr;
   assign frame_end = line_end & (lcnt == nd);
   assign graphic   = mode[lcdtc_pkg::MODE_GRAPHIC];
   assign window    = mode[lcdtc_pkg::MODE_ON] & (hcnt < nhd);
   assign ma_now    = row_addr + {8'h00, hcnt};

   // P alone blanks; B blinks at 32 or 64 frames
   assign cur_visible = cur_b ? (cur_p ? fcnt[5] : fcnt[4]) : ~cur_p;
   assign cursor_now  = window & cur_visible & (ma_now == cur_addr)
                      & (ras >= ncs) & (ras <= nce);

   // Counters clear while the pin is low and restart after its rise
   assign next_state    = pin_rst ? lcdtc_pkg::ST_HOLD : lcdtc_pkg::ST_RUN;
   assign next_hcnt     = (pin_rst || line_end) ? 8'h00 : hcnt + 8'h01;
   assign next_lcnt     = (pin_rst || frame_end) ? 9'h000
                        : line_end ? lcnt + 9'h001 : lcnt;
   assign next_fcnt     = pin_rst ? 6'h00 : frame_end ? fcnt + 6'h01 : fcnt;
   assign next_ras      = pin_rst ? 5'h00
                        : frame_end ? nsr
                        : line_end ? (row_end ? 5'h00 : ras + 5'h01) : ras;
   // Next row begins one virtual width further on
   assign next_row_addr = pin_rst ? 16'h0000
                        : frame_end ? start_addr
                        : (line_end && row_end) ? row_addr + {8'h00, nir}
                        : row_addr;

   // Normal output values
   assign run_val.upper_panel_data      = window ? md[7:4] : 4'h0;
   assign run_val.lower_panel_data      = window ? md[3:0] : 4'h0;
   assign run_val.frame_start_marker    = frame_end;
   assign run_val.line_latch_clock      = line_end;
   assign run_val.shift_clock_out       = window ? ~disp_q.shift_clock_out : graphic;
   assign run_val.raster_row_address    = ras;
   assign run_val.memory_clock_out      = ~disp_q.memory_clock_out;
   assign run_val.display_window_timing = window;
   assign run_val.cursor_display_out    = cursor_now;
   assign run_val.memory_address_out    = ma_now;

   // Reset caught inside the window pulls the window group low
   assign entering = (state == lcdtc_pkg::ST_RUN) & pin_rst;
   assign drop_low = entering & disp_q.display_window_timing;

   assign hold_val.upper_panel_data      = disp_q.upper_panel_data;
   assign hold_val.lower_panel_data      = disp_q.lower_panel_data;
   assign hold_val.frame_start_marker    = disp_q.frame_start_marker;
   assign hold_val.line_latch_clock      = disp_q.line_latch_clock;
   assign hold_val.raster_row_address    = disp_q.raster_row_address;
   assign hold_val.memory_clock_out      = 1'b1;
   // Idles high in graphic mode, low in character mode
   assign hold_val.shift_clock_out       = graphic;
   assign hold_val.display_window_timing = drop_low ? 1'b0
                                         : disp_q.display_window_timing;
   assign hold_val.cursor_display_out    = drop_low ? 1'b0
                                         : disp_q.cursor_display_out;
   assign hold_val.memory_address_out    = drop_low ? 16'h0000
                                         : disp_q.memory_address_out;

   assign next_disp = pin_rst ? hold_val : run_val;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state    <= lcdtc_pkg::ST_RUN;
         hcnt     <= 8'h00;
         ras      <= 5'h00;
         lcnt     <= 9'h000;
         row_addr <= 16'h0000;
         fcnt     <= 6'h00;
         disp_q   <= lcdtc_pkg::DISP_RST_VAL;
      end else if (ce_i) begin
         state    <= next_state;
         hcnt     <= next_hcnt;
         ras      <= next_ras;
         lcnt     <= next_lcnt;
         row_addr <= next_row_addr;
         fcnt     <= next_fcnt;
         disp_q   <= next_disp;
      end
   end

   assign disp_o = disp_q;

   // Read channel
   logic [4:0]  rd_idx;
   logic        rd_hit;
   logic        rd_status;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   assign rd_idx      = s_axi_araddr[6:2];
   assign rd_status   = rd_idx == lcdtc_pkg::IDX_STATUS;
   assign rd_hit      = lcdtc_pkg::IMPL_MASK[rd_idx] | rd_status;
   assign status_word = (32'(pin_rst) << lcdtc_pkg::ST_PIN_RESET)
                      | (32'(disp_q.display_window_timing) << lcdtc_pkg::ST_WINDOW)
                      | (32'(graphic) << lcdtc_pkg::ST_GRAPHIC)
                      | (32'(ras) << lcdtc_pkg::ST_RASTER_LSB)
                      | (32'(lcnt) << lcdtc_pkg::ST_LINE_LSB);
   assign rd_word     = rd_status ? status_word
                      : lcdtc_pkg::IMPL_MASK[rd_idx] ? {24'h000000, regs[rd_idx]}
                      : 32'h00000000;

   assign s_axi_arready = ce_i & ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= lcdtc_pkg::RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? lcdtc_pkg::RESP_OKAY : lcdtc_pkg::RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

endmodule : lcdtc_core

`default_nettype wire

// File: rtl/lcdtc_pkg.sv
package lcdtc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [4:0]  IDX_HTOTAL    = 5'h00;
   localparam logic [4:0]  IDX_HDISP     = 5'h01;
   localparam logic [4:0]  IDX_MAXRAS    = 5'h09;
   localparam logic [4:0]  IDX_CUR_START = 5'h0A;
   localparam logic [4:0]  IDX_CUR_END   = 5'h0B;
   localparam logic [4:0]  IDX_START_H   = 5'h0C;
   localparam logic [4:0]  IDX_START_L   = 5'h0D;
   localparam logic [4:0]  IDX_CUR_H     = 5'h0E;
   localparam logic [4:0]  IDX_CUR_L     = 5'h0F;
   localparam logic [4:0]  IDX_VWIDTH    = 5'h12;
   localparam logic [4:0]  IDX_DUTY_H    = 5'h13;
   localparam logic [4:0]  IDX_DUTY_L    = 5'h14;
   localparam logic [4:0]  IDX_SCROLL    = 5'h15;
   localparam logic [4:0]  IDX_MODE      = 5'h16;
   localparam logic [4:0]  IDX_STATUS    = 5'h18;
   localparam int unsigned REG_COUNT     = 23;
   localparam int unsigned ADDR_W_MIN    = 7;

   // One bit per writable index
   localparam logic [31:0] IMPL_MASK     = 32'h007CFE03;
   localparam logic [7:0]  REG_RST_VAL   = 8'h00;

   // Mode register fields
   localparam int unsigned MODE_AT       = 0;
   localparam int unsigned MODE_BLE      = 1;
   localparam int unsigned MODE_WIDE     = 2;
   localparam int unsigned MODE_GRAPHIC  = 3;
   localparam int unsigned MODE_ON       = 4;
   localparam int unsigned MODE_W        = 5;

   // Cursor start register fields
   localparam int unsigned CUR_P_BIT     = 5;
   localparam int unsigned CUR_B_BIT     = 6;

   // Status register fields
   localparam int unsigned ST_PIN_RESET  = 0;
   localparam int unsigned ST_WINDOW     = 1;
   localparam int unsigned ST_GRAPHIC    = 2;
   localparam int unsigned ST_RASTER_LSB = 8;
   localparam int unsigned ST_LINE_LSB   = 16;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned MD_W          = 8;

   typedef enum logic [1:0] {
      ST_RUN  = 2'h1,
      ST_HOLD = 2'h2
   } lcdtc_state_e;

   typedef struct packed {
      logic [3:0]  upper_panel_data;
      logic [3:0]  lower_panel_data;
      logic        frame_start_marker;
      logic        line_latch_clock;
      logic        shift_clock_out;
      logic [4:0]  raster_row_address;
      logic        memory_clock_out;
      logic        display_window_timing;
      logic        cursor_display_out;
      logic [15:0] memory_address_out;
   } lcdtc_disp_s;

   localparam lcdtc_disp_s DISP_RST_VAL = '0;

endpackage : lcdtc_pkg

// File: rtl/lcdtc_sync.sv
`timescale 1ns/100ps
`default_nettype none

module lcdtc_sync #(
   parameter int unsigned     WIDTH   = 1,
   parameter int unsigned     STAGES  = lcdtc_pkg::SYNC_STAGES,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] pipe [STAGES];

   if (STAGES < 2) begin : g_chk
      $error("lcdtc_sync needs at least two stages");
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < STAGES; i++) pipe[i] <= RST_VAL;
      end else if (ce_i) begin
         pipe[0] <= async_i;
         for (int i = 1; i < STAGES; i++) pipe[i] <= pipe[i-1];
      end
   end

   assign sync_o = pipe[STAGES-1];

endmodule : lcdtc_sync

`default_nettype wire

// File: verif/lcdtc_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module lcdtc_monitor (
   input  wire logic                   clk_sys_i,
   input  wire logic                   rst_b_i,
   input  wire logic                   ce_i,
   input  wire logic                   lcd_reset_b_i,
   input  wire logic [4:0]             mode_pins_i,
   input  wire lcdtc_pkg::lcdtc_disp_s disp_o,
   input  wire logic                   s_axi_awvalid,
   input  wire logic                   s_axi_awready,
   input  wire logic                   s_axi_wvalid,
   input  wire logic                   s_axi_wready,
   input  wire logic                   s_axi_bvalid,
   input  wire logic                   s_axi_arvalid,
   input  wire logic                   s_axi_arready,
   input  wire logic [31:0]            s_axi_rdata,
   input  wire logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   // Five samples cover the two sync flops plus the output register
   sequence s_held;
      (!lcd_reset_b_i && ce_i) [*5];
   endsequence
   sequence s_held_gfx;
      (!lcd_reset_b_i && ce_i && mode_pins_i[3]) [*5];
   endsequence

   property p_mclk_high;
      s_held |-> disp_o.memory_clock_out;
   endproperty
   property p_panel_hold;
      s_held |-> $stable(disp_o.upper_panel_data) && $stable(disp_o.lower_panel_data)
         && $stable(disp_o.frame_start_marker) && $stable(disp_o.line_latch_clock)
         && $stable(disp_o.raster_row_address);
   endproperty
   property p_window_low;
      s_held |-> !disp_o.display_window_timing;
   endproperty
   property p_addr_hold;
      s_held |-> $stable(disp_o.memory_address_out) && $stable(disp_o.cursor_display_out);
   endproperty
   property p_shift_fixed;
      s_held |-> $stable(disp_o.shift_clock_out);
   endproperty
   property p_shift_gfx;
      s_held_gfx |-> disp_o.shift_clock_out;
   endproperty
   property p_resume;
      $rose(lcd_reset_b_i) |-> ##[1:6] !disp_o.memory_clock_out;
   endproperty
   property p_bresp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
   endproperty
   property p_rvalid;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_bus_free;
      !lcd_reset_b_i && ce_i && s_axi_arvalid && !s_axi_rvalid |-> s_axi_arready;
   endproperty
   property p_rstand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty

   a_mclk_high: assert property (p_mclk_high)
      else $error("memory clock low while held");
   a_panel_hold: assert property (p_panel_hold)
      else $error("panel outputs moved while held");
   a_window_low: assert property (p_window_low)
      else $error("window high while held");
   a_addr_hold: assert property (p_addr_hold)
      else $error("address moved while held");
   a_shift_fixed: assert property (p_shift_fixed)
      else $error("shift clock toggled in reset");
   a_shift_gfx: assert property (p_shift_gfx)
      else $error("shift clock level wrong");
   a_resume: assert property (p_resume)
      else $error("memory clock did not restart");
   a_bresp: assert property (p_bresp)
      else $error("write answer late");
   a_rvalid: assert property (p_rvalid)
      else $error("read answer late");
   a_bus_free: assert property (p_bus_free)
      else $error("bus stalled by panel reset");
   a_rstand: assert property (p_rstand)
      else $error("read data dropped early");
endmodule : lcdtc_monitor

bind lcdtc_core lcdtc_monitor i_lcdtc_monitor (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .lcd_reset_b_i(lcd_reset_b_i),
   .mode_pins_i(mode_pins_i), .disp_o(disp_o), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

`default_nettype wire

// File: verif/lcdtc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module lcdtc_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   input  wire logic [15:0] addr_i,
   output logic      [7:0]  data_o
);
   logic [7:0] lfsr;

   // Data changes every cycle, so a held output cannot pass by stale input
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lfsr   <= 8'h01;
         data_o <= 8'h00;
      end else begin
         lfsr   <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         data_o <= addr_i[7:0] ^ lfsr;
      end
   end
endmodule : lcdtc_mem_model

`default_nettype wire

// File: verif/lcd_timing_reset_and_limits_test.sv
`timescale 1ns/100ps
`default_nettype none

module lcd_timing_reset_and_limits_test;
   logic                   clk_sys_i, rst_b_i, ce_i, lcd_reset_b_i;
   logic [4:0]             mode_pins_i;
   logic [7:0]             mem_data;
   lcdtc_pkg::lcdtc_disp_s disp;
   logic [6:0]             awaddr, araddr;
   logic [31:0]            wdata, rdata;
   logic [3:0]             wstrb;
   logic [1:0]             bresp, rresp;
   logic                   awvalid, awready, wvalid, wready, bvalid, bready;
   logic                   arvalid, arready, rvalid, rready;
   int                     fails, checks_done;
   int                     model_reg [32];
   logic [4:0]             pidx [9] = '{5'h00, 5'h01, 5'h09, 5'h0A, 5'h12, 5'h13, 5'h14, 5'h0C, 5'h16};
   logic [7:0]             pval [9] = '{8'h1F, 8'h08, 8'h00, 8'h20, 8'h0A, 8'h00, 8'h03, 8'h01, 8'h10};

   lcdtc_core i_lcdtc_core (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .lcd_reset_b_i(lcd_reset_b_i),
      .mode_pins_i(mode_pins_i), .mem_data_i(mem_data), .disp_o(disp),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );
   lcdtc_mem_model i_lcdtc_mem_model (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .addr_i(disp.memory_address_out),
      .data_o(mem_data)
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run

   function automatic logic [1:0] exp_resp(input logic [4:0] idx);
      return lcdtc_pkg::IMPL_MASK[idx] ? lcdtc_pkg::RESP_OKAY : lcdtc_pkg::RESP_SLVERR;
   endfunction : exp_resp

   task automatic axi_wr(input logic [4:0] idx, input logic [7:0] d, input logic [3:0] st);
      logic [1:0] rsp;
      logic       a, w, b;
      int         n;
      @(posedge clk_sys_i);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      b = 1'b0;
      while (!b && n < 50) begin
         @(negedge clk_sys_i);
         a = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         rsp = bresp;
         @(posedge clk_sys_i);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      check(32'(b), 32'h1);
      check(32'(rsp), 32'(exp_resp(idx)));
      if (lcdtc_pkg::IMPL_MASK[idx] && st[0]) model_reg[idx] = d;
   endtask : axi_wr

   task automatic axi_rd(input logic [4:0] idx, output logic [31:0] d, output logic [1:0] rsp);
      logic a, r;
      int   n;
      @(posedge clk_sys_i);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      r = 1'b0;
      while (!r && n < 50) begin
         @(negedge clk_sys_i);
         a = arvalid && arready;
         r = rvalid;
         d = rdata;
         rsp = rresp;
         @(posedge clk_sys_i);
         if (a) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      check(32'(r), 32'h1);
   endtask : axi_rd

   task automatic rd_chk(input logic [4:0] idx);
      logic [31:0] d;
      logic [1:0]  rsp;
      logic        st;
      st = idx == lcdtc_pkg::IDX_STATUS;
      axi_rd(idx, d, rsp);
      // Status counter fields run freely; pin reset and graphic bits are known
      if (st) check(d & 32'h00000005,
                    {29'h0, model_reg[lcdtc_pkg::IDX_MODE][3] | mode_pins_i[3], 2'h0});
      else check(d, lcdtc_pkg::IMPL_MASK[idx] ? 32'(model_reg[idx]) : 32'h0);
      check(32'(rsp), st ? 32'(lcdtc_pkg::RESP_OKAY) : 32'(exp_resp(idx)));
   endtask : rd_chk

   task automatic panel_reset(input logic gfx);
      logic [31:0] d;
      logic [1:0]  rsp;
      logic        m0;
      @(posedge clk_sys_i);
      lcd_reset_b_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check(32'(disp.shift_clock_out), 32'(gfx));
      check(32'(disp.memory_clock_out), 32'h1);
      check(32'(disp.display_window_timing), 32'h0);
      axi_wr(lcdtc_pkg::IDX_VWIDTH, 8'($urandom()), 4'hF);
      rd_chk(lcdtc_pkg::IDX_VWIDTH);
      axi_rd(lcdtc_pkg::IDX_STATUS, d, rsp);
      check(d & 32'h01FF1F07, {29'h0, gfx, 2'h1});
      // Low time well above 1 us at 100 MHz
      repeat (100) @(posedge clk_sys_i);
      lcd_reset_b_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      m0 = disp.memory_clock_out;
      @(negedge clk_sys_i);
      check(32'(disp.memory_clock_out), 32'(!m0));
      for (int i = 0; i < 32; i++) if (lcdtc_pkg::IMPL_MASK[i]) rd_chk(5'(i));
      $display("panel reset test done");
   endtask : panel_reset

   initial begin
      #(60000 * 10);
      fails++;
      complete_run();
   end

   initial begin
      logic [15:0] prev;
      logic        have, wprev;
      int          cnt, n;
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      lcd_reset_b_i = 1'b1;
      mode_pins_i = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      for (int i = 0; i < 32; i++) model_reg[i] = 0;
      void'($urandom(39977));
      repeat (5) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 32; i++) rd_chk(5'(i));
      axi_wr(5'h02, 8'h5A, 4'hF);
      axi_wr(lcdtc_pkg::IDX_STATUS, 8'h5A, 4'hF);
      $display("reset value and map test done");
      for (int i = 0; i < 32; i++)
         if (lcdtc_pkg::IMPL_MASK[i]) axi_wr(5'(i), 8'($urandom()), 4'hF);
      axi_wr(lcdtc_pkg::IDX_HDISP, 8'hC3, 4'hE);
      for (int i = 0; i < 32; i++) rd_chk(5'(i));
      $display("register access test done");
      // Nhd 8, total 32, Nir 10, four lines a frame keep every limit
      for (int i = 0; i < 9; i++) axi_wr(pidx[i], pval[i], 4'hF);
      axi_wr(lcdtc_pkg::IDX_START_L, 8'h00, 4'hF);
      axi_wr(lcdtc_pkg::IDX_SCROLL, 8'h00, 4'hF);
      // Raster and line counters left by random settings would stall rows
      lcd_reset_b_i <= 1'b0;
      repeat (100) @(posedge clk_sys_i);
      lcd_reset_b_i <= 1'b1;
      have = 1'b0;
      wprev = 1'b0;
      cnt = 0;
      n = 0;
      while (cnt < 12 && n < 4000) begin
         @(negedge clk_sys_i);
         n++;
         if (disp.frame_start_marker) have = 1'b0;
         if (disp.display_window_timing && !wprev) begin
            if (have) check(32'(disp.memory_address_out), 32'(prev + 16'h000A));
            prev = disp.memory_address_out;
            have = 1'b1;
            cnt++;
         end
         wprev = disp.display_window_timing;
      end
      check(32'(cnt), 32'h0000000C);
      $display("row address test done");
      panel_reset(1'b0);
      @(posedge clk_sys_i);
      mode_pins_i <= 5'h08;
      repeat (5) @(posedge clk_sys_i);
      panel_reset(1'b1);
      @(posedge clk_sys_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      for (int i = 0; i < 32; i++) model_reg[i] = 0;
      rd_chk(lcdtc_pkg::IDX_HDISP);
      $display("system reset test done");
      complete_run();
   end
endmodule : lcd_timing_reset_and_limits_test

`default_nettype wire
